/* File: kmu_pkg.sv */
package kmu_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_MASK = 2'h0;
  localparam logic [1:0] ADDR_PATTERN = 2'h1;
  localparam logic [1:0] ADDR_CONTROL = 2'h2;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_SENSE_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic SENSE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing: match must stand longer than this many cpu_clock cycles
  // ----------------------------------------------------------------
  localparam int PERSIST_CPU_CLOCKS = 6;
  localparam logic [2:0] PERSIST_LAST = 3'(PERSIST_CPU_CLOCKS);
endpackage : kmu_pkg

/* File: kmu_keypad_match_unit.sv */
`timescale 1ns/1ps
// Contract
// - mask selects pins taking part
// - compare port against written pattern, masked
// - set flag when condition holds, while active
// - flag and enable raise one interrupt
// - sense bit picks equal or not-equal
// - enabled interrupt wakes from idle, power-down
// - match must persist over six clocks
module kmu_keypad_match_unit #(
  parameter int PORT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [PORT_W-1:0] port0_i,
  input wire logic [1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic int_enable_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PORT_W != 8)
  begin : g_bad_width
    $error("port width must be 8 to fit the byte registers");
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [7:0] port_meta_q;
  logic [7:0] port_sync_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_meta_q <= 8'h00;
      port_sync_q <= 8'h00;
    end
    else
    begin
      port_meta_q <= port0_i;
      port_sync_q <= port_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] mask_q;
  logic [7:0] pattern_q;
  logic sense_q;
  logic flag_q;
  logic wr_mask;
  logic wr_pattern;
  logic wr_control;

  assign wr_mask = sfr_wr_i && (sfr_addr_i == kmu_pkg::ADDR_MASK);
  assign wr_pattern = sfr_wr_i && (sfr_addr_i == kmu_pkg::ADDR_PATTERN);
  assign wr_control = sfr_wr_i && (sfr_addr_i == kmu_pkg::ADDR_CONTROL);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mask_q <= kmu_pkg::MASK_RESET;
      pattern_q <= kmu_pkg::PATTERN_RESET;
      sense_q <= kmu_pkg::SENSE_RESET;
    end
    else
    begin
      if (wr_mask)
        mask_q <= sfr_wdata_i;
      if (wr_pattern)
        pattern_q <= sfr_wdata_i;
      if (wr_control)
        sense_q <= sfr_wdata_i[kmu_pkg::CTRL_SENSE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // comparison
  // ----------------------------------------------------------------
  logic active;
  logic masked_equal;
  logic match;

  // an all-zero mask means no pin can take part, so the unit idles
  assign active = (mask_q != 8'h00);
  assign masked_equal =
    ((port_sync_q & mask_q) == (pattern_q & mask_q));
  assign match = active && (sense_q ? !masked_equal : masked_equal);

  // ----------------------------------------------------------------
  // persistence filter
  // ----------------------------------------------------------------
  logic [2:0] persist_q;
  logic set_flag;

  // saturates so a long match keeps re-setting the flag
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      persist_q <= 3'h0;
    else if (!match)
      persist_q <= 3'h0;
    else if (persist_q != kmu_pkg::PERSIST_LAST)
      persist_q <= persist_q + 3'h1;
  end

  // seventh consecutive matching cycle, i.e. more than six
  assign set_flag =
    match && (persist_q == kmu_pkg::PERSIST_LAST);

  // ----------------------------------------------------------------
  // sticky flag
  // ----------------------------------------------------------------
  // set wins over a same-cycle clear; writing one does not set it
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flag_q <= 1'b0;
    else if (set_flag)
      flag_q <= 1'b1;
    else if (wr_control && !sfr_wdata_i[kmu_pkg::CTRL_FLAG_BIT])
      flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // interrupt and wake
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end
    else
    begin
      irq_o <= flag_q && int_enable_i;
      wake_o <= flag_q && int_enable_i;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      unique case (sfr_addr_i)
        kmu_pkg::ADDR_MASK: sfr_rdata_o <= mask_q;
        kmu_pkg::ADDR_PATTERN: sfr_rdata_o <= pattern_q;
        kmu_pkg::ADDR_CONTROL: sfr_rdata_o <= {6'h00, sense_q, flag_q};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mask_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!flag_q && mask_q == 8'h00) |=> !flag_q)
    else $error("flag set with no pin enabled");

  pattern_read_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_pattern ##1
      (sfr_rd_i && sfr_addr_i == kmu_pkg::ADDR_PATTERN && !sfr_wr_i))
    |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("pattern readback differs from write");

  match_sets_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    match [*7] |=> flag_q)
    else $error("flag not set after persistent match");

  irq_out_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (flag_q && int_enable_i) |=> irq_o)
    else $error("interrupt missing for enabled flag");

  sense_eq_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (active && !sense_q && (port_sync_q & mask_q) != (pattern_q & mask_q))
    |-> !match)
    else $error("equal sense matched a differing port");

  wake_out_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    wake_o |-> $past(flag_q) && $past(int_enable_i))
    else $error("wake without enabled flag");

  short_match_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(flag_q)
    |-> $past(match) && $past(persist_q) == kmu_pkg::PERSIST_LAST)
    else $error("flag set by a short match");

  sticky_flag_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (flag_q && !wr_control) |=> flag_q)
    else $error("flag dropped without software clear");

  // a clear landing with a fresh match must lose
  set_wins_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    set_flag |=> flag_q)
    else $error("match lost to a same-cycle clear");

  sense_ne_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (sense_q && (port_sync_q & mask_q) == (pattern_q & mask_q))
    |-> !set_flag)
    else $error("differ sense flagged an equal port");

  irq_drop_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !(flag_q && int_enable_i) |=> !irq_o)
    else $error("interrupt without enabled flag");

  flag_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_control && !sfr_wdata_i[kmu_pkg::CTRL_FLAG_BIT] && !set_flag)
    |=> !flag_q)
    else $error("flag kept after software clear");

  // writing one to the flag bit must never raise it
  flag_source_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!flag_q && !set_flag) |=> !flag_q)
    else $error("flag raised without a match");

endmodule : kmu_keypad_match_unit

/* File: kmu_keypad_model.sv */
`timescale 1ns/1ps
// ----
// keypad switches on port 0
// ----
module kmu_keypad_model (
  input wire logic [7:0] key_down_i,
  output logic [7:0] port0_o
);
  // pressed key shorts its pin low; open pins sit at the pull-up level
  assign port0_o = ~key_down_i;
endmodule : kmu_keypad_model

/* File: testbench.sv */
`timescale 1ns/1ps
// ----
// register access and match tests
// ----
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ien = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] keys = 8'h00;
  logic [7:0] port;
  logic [7:0] rdata;
  logic irq;
  logic wake;
  int bad_count = 0;
  int compares = 0;

  always #25 clk = ~clk;

  kmu_keypad_model pad_u (.key_down_i(keys), .port0_o(port));

  kmu_keypad_match_unit dut_u (
    .core_clk_i(clk), .arst_n_i(rst_n), .port0_i(port),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wd), .int_enable_i(ien), .sfr_rdata_o(rdata),
    .irq_o(irq), .wake_o(wake)
  );

  task close_out;
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #2 wr = 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    #2 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #2 rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_reg

  // write then read back on the very next cycle
  task wr_rd(input logic [1:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    @(posedge clk);
    #2 addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #2 wr = 1'b0;
    rd = 1'b1;
    @(posedge clk);
    #2 rd = 1'b0;
    chk(rdata, exp);
  endtask : wr_rd

  // holds the keys for n sampling edges, then lets the sync drain
  task press(input logic [7:0] v, input int n);
    @(posedge clk);
    #2 keys = v;
    repeat (n) @(posedge clk);
    #2 keys = 8'h00;
    repeat (4) @(posedge clk);
  endtask : press

  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h2, 8'h00);
    wr_reg(2'h3, 8'h5a);
    rd_reg(2'h3, 8'h00);
    wr_reg(2'h1, 8'haa);
    rd_reg(2'h1, 8'haa);
    wr_reg(2'h2, 8'hff);
    rd_reg(2'h2, 8'h02);
    wr_reg(2'h1, 8'hff);
    wr_reg(2'h0, 8'h0f);
    rd_reg(2'h0, 8'h0f);
    ien = 1'b1;
    press(8'h20, 10);
    rd_reg(2'h2, 8'h02);
    press(8'h02, 6);
    rd_reg(2'h2, 8'h02);
    press(8'h02, 7);
    rd_reg(2'h2, 8'h03);
    chk({6'h00, wake, irq}, 8'h03);
    ien = 1'b0;
    repeat (2) @(posedge clk);
    #2 chk({6'h00, wake, irq}, 8'h00);
    rd_reg(2'h2, 8'h03);
    wr_reg(2'h2, 8'h02);
    rd_reg(2'h2, 8'h02);
    wr_reg(2'h2, 8'h00);
    wr_reg(2'h0, 8'hff);
    wr_rd(2'h1, 8'ha5, 8'ha5);
    press(8'h5a, 8);
    rd_reg(2'h2, 8'h01);
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h2, 8'h00);
    press(8'h5a, 8);
    rd_reg(2'h2, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    rd_reg(2'h1, 8'h00);
    rd_reg(2'h0, 8'h00);
    close_out();
  end
endmodule : testbench
